// >>> core/tlf_pkg.sv
// constants for the translation fault and mapped address-array block
package tlf_pkg;
  // geometry of the translation buffer
  localparam int TLF_WAYS = 4;
  localparam int TLF_SETS = 32;
  // exception event codes
  localparam logic [11:0] TLF_EXC_PROT_LD = 12'h0a0;
  localparam logic [11:0] TLF_EXC_PROT_ST = 12'h0c0;
  localparam logic [11:0] TLF_EXC_INV_LD = 12'h040;
  localparam logic [11:0] TLF_EXC_INV_ST = 12'h060;
  localparam logic [11:0] TLF_EXC_FIRST_WR = 12'h080;
  localparam logic [11:0] TLF_EXC_RESET = 12'h000;
  // vector offset for general exceptions
  localparam logic [31:0] TLF_VEC_GEN_OFS = 32'h0000_0100;
  // status register bit positions
  localparam int TLF_SR_PRIV = 30;
  localparam int TLF_SR_BANK = 29;
  localparam int TLF_SR_MASK = 28;
  // mapped access decode
  localparam logic [7:0] TLF_MA_ADDR_SEL = 8'hf2;
  localparam logic [1:0] TLF_SIZE_LONG = 2'h2;
  // address-array word layout: vpn 31:10, valid 8, space id 7:0
  localparam int TLF_AA_VALID = 8;
  // page-entry-low layout
  localparam int TLF_PEL_VALID = 8;
  localparam int TLF_PEL_RIGHTS_HI = 6;
  localparam int TLF_PEL_RIGHTS_LO = 5;
  localparam int TLF_PEL_SIZE = 4;
  localparam int TLF_PEL_DIRTY = 2;
  localparam int TLF_PEL_SHARE = 1;
  // reset values
  localparam logic [31:0] TLF_WORD_RST = 32'h0000_0000;
  localparam logic [1:0] TLF_WAY_RST = 2'h0;
  // outcome of one lookup
  typedef enum logic [1:0] {
    TLF_NONE = 2'b00,
    TLF_PROT = 2'b01,
    TLF_INV = 2'b10,
    TLF_FIRSTW = 2'b11
  } tlf_fault_t;
endpackage

// >>> core/tlf_fault_map.sv
// translation fault detection, fault capture and mapped address-array access
// Contract
// - protection fault when rights forbid the access
// - protection code 0a0 load, 0c0 store
// - protection fault records offending way
// - all three faults vector to base plus 100
// - capture page number and full fault address
// - save pc, or branch pc in delay slot
// - save status, set privilege, mask, bank bits
// - invalid fault when matching entry not valid
// - invalid code 040 load, 060 store
// - invalid fault records matching way
// - first-write fault on clean writable store hit
// - first-write code 080 for any access
// - first-write fault records offending way
// - address array mapped at f2000000 to f2ffffff
// - mapped accesses are longword only
// - index bits 16-12, way 9-8, select f2
// - array read returns page, valid, space id
// - array write stores word into chosen entry; an entry load in the same cycle wins and the write is dropped
// - hash mode xors page bits with space id
// - way field maps 00..11 to ways 0..3
`timescale 1ns/10ps
`default_nettype none
module tlf_fault_map
  import tlf_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  // lookup request from the core
  input wire logic lk_req_i,
  input wire logic [31:0] lk_vaddr_i,
  input wire logic lk_store_i,
  input wire logic [31:0] lk_pc_i,
  input wire logic lk_delay_slot_i,
  input wire logic [31:0] lk_branch_pc_i,
  input wire logic [31:0] status_i,
  input wire logic [31:0] vector_base_i,
  // software writes of control state
  input wire logic index_hash_mode_i,
  input wire logic page_entry_high_reg_we_i,
  input wire logic page_entry_low_reg_we_i,
  input wire logic rc_we_i,
  input wire logic [31:0] sw_wdata_i,
  input wire logic load_xlate_entry_op_i,
  // mapped address-array access
  input wire logic ma_req_i,
  input wire logic ma_write_i,
  input wire logic [1:0] ma_size_i,
  input wire logic [31:0] ma_addr_i,
  input wire logic [31:0] ma_wdata_i,
  // lookup results
  output logic lk_done_o,
  output logic lk_hit_o,
  output logic fault_o,
  output logic [11:0] exc_code_o,
  output logic [31:0] fault_addr_o,
  output logic [31:0] page_entry_high_o,
  output logic [31:0] page_entry_low_o,
  output logic [1:0] replace_way_o,
  output logic [31:0] saved_pc_o,
  output logic [31:0] saved_status_o,
  output logic [31:0] status_o,
  output logic [31:0] vector_pc_o,
  // mapped access answer
  output logic ma_ack_o,
  output logic ma_err_o,
  output logic [31:0] ma_rdata_o
);

  // entry index, optionally hashed with the space id
  function automatic logic [4:0] hash_idx(input logic [4:0] pg, input logic [4:0] sid,
                                          input logic hash);
    hash_idx = hash ? (pg ^ sid) : pg;
  endfunction

  // rights check: 00 priv read, 01 priv rw, 10 priv rw user read, 11 all rw
  function automatic logic rights_ok(input logic [1:0] r, input logic priv, input logic st);
    if (st)
      rights_ok = (r == 2'b11) || (priv && (r != 2'b00));
    else
      rights_ok = priv || r[1];
  endfunction

  // address array storage
  logic [21:0] tag_q [TLF_WAYS][TLF_SETS]; // vpn bits 31:10
  logic [7:0] sid_q [TLF_WAYS][TLF_SETS]; // space id
  logic vld_q [TLF_WAYS][TLF_SETS]; // valid flag
  // data array attributes used by the checks
  logic [1:0] rgt_q [TLF_WAYS][TLF_SETS]; // access rights
  logic sz4k_q [TLF_WAYS][TLF_SETS]; // 4k page when set
  logic dirty_q [TLF_WAYS][TLF_SETS]; // written flag
  logic shr_q [TLF_WAYS][TLF_SETS]; // shared across space ids

  // control registers
  logic [31:0] page_entry_high_reg_q; // page entry high
  logic [31:0] page_entry_low_reg_q; // page entry low
  logic [1:0] rc_q; // replacement way pointer

  // lookup decode
  logic [4:0] lk_idx;
  logic [TLF_WAYS-1:0] amatch;
  logic any_match;
  logic [1:0] hit_way;
  logic hit_v;
  logic hit_ok;
  logic hit_dirty;
  tlf_fault_t fault_d;

  assign lk_idx = hash_idx(lk_vaddr_i[16:12], page_entry_high_reg_q[4:0], index_hash_mode_i);

  // per-way address comparison, valid flag deliberately ignored
  generate
    for (genvar w = 0; w < TLF_WAYS; w++)
    begin : g_cmp
      assign amatch[w] = (tag_q[w][lk_idx][21:7] == lk_vaddr_i[31:17])
                         && (sz4k_q[w][lk_idx] || (tag_q[w][lk_idx][1:0] == lk_vaddr_i[11:10]))
                         && (shr_q[w][lk_idx] || (sid_q[w][lk_idx] == page_entry_high_reg_q[7:0]));
    end
  endgenerate

  // pick lowest matching way and classify the outcome
  always_comb
  begin
    any_match = 1'b0;
    hit_way = 2'h0;
    for (int w = TLF_WAYS - 1; w >= 0; w--)
    begin
      if (amatch[w])
      begin
        any_match = 1'b1;
        hit_way = 2'(w);
      end
    end
    hit_v = vld_q[hit_way][lk_idx];
    hit_ok = rights_ok(rgt_q[hit_way][lk_idx], status_i[TLF_SR_PRIV], lk_store_i);
    hit_dirty = dirty_q[hit_way][lk_idx];
    if (!any_match)
      fault_d = TLF_NONE; // miss is handled elsewhere
    else if (!hit_v)
      fault_d = TLF_INV;
    else if (!hit_ok)
      fault_d = TLF_PROT;
    else if (lk_store_i && !hit_dirty)
      fault_d = TLF_FIRSTW;
    else
      fault_d = TLF_NONE;
  end

  logic lk_fault;
  assign lk_fault = lk_req_i && (fault_d != TLF_NONE);

  // mapped access decode
  logic [4:0] ma_idx;
  logic [1:0] ma_way;
  logic ma_ok;
  assign ma_idx = hash_idx(ma_addr_i[16:12], page_entry_high_reg_q[4:0], index_hash_mode_i);
  assign ma_way = ma_addr_i[9:8];
  assign ma_ok = (ma_addr_i[31:24] == TLF_MA_ADDR_SEL)
                 && (ma_size_i == TLF_SIZE_LONG)
                 && status_i[TLF_SR_PRIV];

  // load_xlate_entry_op target index from page entry high
  logic [4:0] ld_idx;
  assign ld_idx = hash_idx(page_entry_high_reg_q[16:12], page_entry_high_reg_q[4:0], index_hash_mode_i);

  // array storage updates: entry load, then mapped write
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      for (int w = 0; w < TLF_WAYS; w++)
      begin
        for (int s = 0; s < TLF_SETS; s++)
        begin
          tag_q[w][s] <= 22'h0;
          sid_q[w][s] <= 8'h0;
          vld_q[w][s] <= 1'b0;
          rgt_q[w][s] <= 2'h0;
          sz4k_q[w][s] <= 1'b0;
          dirty_q[w][s] <= 1'b0;
          shr_q[w][s] <= 1'b0;
        end
      end
    end
    else if (load_xlate_entry_op_i)
    begin
      // load the way chosen by the replacement pointer
      tag_q[rc_q][ld_idx] <= page_entry_high_reg_q[31:10];
      sid_q[rc_q][ld_idx] <= page_entry_high_reg_q[7:0];
      vld_q[rc_q][ld_idx] <= page_entry_low_reg_q[TLF_PEL_VALID];
      rgt_q[rc_q][ld_idx] <= page_entry_low_reg_q[TLF_PEL_RIGHTS_HI:TLF_PEL_RIGHTS_LO];
      sz4k_q[rc_q][ld_idx] <= page_entry_low_reg_q[TLF_PEL_SIZE];
      dirty_q[rc_q][ld_idx] <= page_entry_low_reg_q[TLF_PEL_DIRTY];
      shr_q[rc_q][ld_idx] <= page_entry_low_reg_q[TLF_PEL_SHARE];
    end
    else if (ma_req_i && ma_write_i && ma_ok)
    begin
      // address-array write keeps the data-array attributes
      tag_q[ma_way][ma_idx] <= ma_wdata_i[31:10];
      vld_q[ma_way][ma_idx] <= ma_wdata_i[TLF_AA_VALID];
      sid_q[ma_way][ma_idx] <= ma_wdata_i[7:0];
    end
  end

  // page entry registers: hardware capture beats a software write
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      page_entry_high_reg_q <= TLF_WORD_RST;
      page_entry_low_reg_q <= TLF_WORD_RST;
    end
    else
    begin
      if (lk_fault)
        page_entry_high_reg_q <= {lk_vaddr_i[31:10], page_entry_high_reg_q[9:0]};
      else if (page_entry_high_reg_we_i)
        page_entry_high_reg_q <= sw_wdata_i;
      if (page_entry_low_reg_we_i)
        page_entry_low_reg_q <= sw_wdata_i;
    end
  end

  // replacement way pointer
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
      rc_q <= TLF_WAY_RST;
    else if (lk_fault)
      rc_q <= hit_way;
    else if (rc_we_i)
      rc_q <= sw_wdata_i[1:0];
  end

  // fault capture of code, address, pc, status and vector
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      exc_code_o <= TLF_EXC_RESET;
      fault_addr_o <= TLF_WORD_RST;
      saved_pc_o <= TLF_WORD_RST;
      saved_status_o <= TLF_WORD_RST;
      status_o <= TLF_WORD_RST;
      vector_pc_o <= TLF_WORD_RST;
    end
    else if (lk_fault)
    begin
      unique case (fault_d)
        TLF_PROT: exc_code_o <= lk_store_i ? TLF_EXC_PROT_ST : TLF_EXC_PROT_LD;
        TLF_INV: exc_code_o <= lk_store_i ? TLF_EXC_INV_ST : TLF_EXC_INV_LD;
        TLF_FIRSTW: exc_code_o <= TLF_EXC_FIRST_WR;
        TLF_NONE: exc_code_o <= exc_code_o;
      endcase
      fault_addr_o <= lk_vaddr_i;
      saved_pc_o <= lk_delay_slot_i ? lk_branch_pc_i : lk_pc_i;
      saved_status_o <= status_i;
      status_o <= status_i | (32'h1 << TLF_SR_PRIV) | (32'h1 << TLF_SR_MASK)
                  | (32'h1 << TLF_SR_BANK);
      vector_pc_o <= vector_base_i + TLF_VEC_GEN_OFS;
    end
  end

  // lookup completion pulses
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      lk_done_o <= 1'b0;
      lk_hit_o <= 1'b0;
      fault_o <= 1'b0;
    end
    else
    begin
      lk_done_o <= lk_req_i;
      lk_hit_o <= lk_req_i && any_match && (fault_d == TLF_NONE);
      fault_o <= lk_fault;
    end
  end

  // mapped access answer
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      ma_ack_o <= 1'b0;
      ma_err_o <= 1'b0;
      ma_rdata_o <= TLF_WORD_RST;
    end
    else
    begin
      ma_ack_o <= ma_req_i && ma_ok;
      ma_err_o <= ma_req_i && !ma_ok;
      if (ma_req_i && ma_ok && !ma_write_i)
        ma_rdata_o <= {tag_q[ma_way][ma_idx], 1'b0, vld_q[ma_way][ma_idx],
                       sid_q[ma_way][ma_idx]};
    end
  end

  // mirrors for the register outputs
  assign page_entry_high_o = page_entry_high_reg_q;
  assign page_entry_low_o = page_entry_low_reg_q;
  assign replace_way_o = rc_q;

  AST_PROT_CODE: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    lk_req_i && fault_d == TLF_PROT |=> fault_o
      && exc_code_o == ($past(lk_store_i) ? TLF_EXC_PROT_ST : TLF_EXC_PROT_LD))
    else $error("protection fault code wrong");

  AST_INV_CODE: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    lk_req_i && any_match && !hit_v |=> fault_o
      && exc_code_o == ($past(lk_store_i) ? TLF_EXC_INV_ST : TLF_EXC_INV_LD))
    else $error("invalid fault code wrong");

  AST_FIRST_WR: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    lk_req_i && lk_store_i && any_match && hit_v && hit_ok && !hit_dirty
      |=> fault_o && exc_code_o == TLF_EXC_FIRST_WR)
    else $error("first write fault missing");

  AST_VECTOR: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    fault_o |-> vector_pc_o == $past(vector_base_i) + TLF_VEC_GEN_OFS)
    else $error("vector address wrong");

  AST_STATUS: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    fault_o |-> saved_status_o == $past(status_i) && status_o[TLF_SR_PRIV]
      && status_o[TLF_SR_MASK] && status_o[TLF_SR_BANK])
    else $error("status save wrong");

  AST_SAVED_PC: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    fault_o |-> saved_pc_o == ($past(lk_delay_slot_i) ? $past(lk_branch_pc_i) : $past(lk_pc_i)))
    else $error("saved pc wrong");

  AST_ADDR: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    fault_o |-> fault_addr_o == $past(lk_vaddr_i)
      && page_entry_high_o[31:10] == fault_addr_o[31:10])
    else $error("fault address capture wrong");

  AST_WAY: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    lk_fault |=> replace_way_o == $past(hit_way))
    else $error("way pointer not updated");

  AST_MA_SIZE: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    ma_req_i && ma_size_i != TLF_SIZE_LONG |=> ma_err_o && !ma_ack_o)
    else $error("non-longword access accepted");

  AST_MA_SEL: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    ma_req_i && ma_addr_i[31:24] != TLF_MA_ADDR_SEL |=> ma_err_o)
    else $error("access outside array accepted");

endmodule
`default_nettype wire

// >>> testbench/tlf_sw_model.sv
// handler-software model: turns bench commands into control writes and entry loads
`timescale 1ns/10ps
`default_nettype none
module tlf_sw_model
  import tlf_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic cmd_go_i,
  input wire logic [1:0] cmd_i,
  input wire logic [31:0] cmd_data_i,
  output logic page_entry_high_reg_we_o,
  output logic page_entry_low_reg_we_o,
  output logic rc_we_o,
  output logic load_op_o,
  output logic [31:0] sw_wdata_o
);
  // one strobe per command, one cycle after the command
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      page_entry_high_reg_we_o <= 1'b0;
      page_entry_low_reg_we_o <= 1'b0;
      rc_we_o <= 1'b0;
      load_op_o <= 1'b0;
    end
    else
    begin
      page_entry_high_reg_we_o <= cmd_go_i && (cmd_i == 2'h0);
      page_entry_low_reg_we_o <= cmd_go_i && (cmd_i == 2'h1);
      rc_we_o <= cmd_go_i && (cmd_i == 2'h2);
      load_op_o <= cmd_go_i && (cmd_i == 2'h3);
    end
  end
  // write data toggles when idle so a stale word is never mistaken for data
  always_ff @(posedge clk_sys_i)
  begin
    if (cmd_go_i)
      sw_wdata_o <= cmd_data_i;
    else
      sw_wdata_o <= ~sw_wdata_o;
  end
endmodule
`default_nettype wire

// >>> testbench/tb_tlf_fault_map.sv
// self-checking bench for the translation fault and mapped access block
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) \
  begin checks_done++; if ((g) !== (e)) begin mismatches++; \
  $display("BAD %s exp %h got %h", n, e, g); end end
module tb_tlf_fault_map
  import tlf_pkg::*;
();
  localparam logic [31:0] PRIV = 32'h4000_00f0; // privileged status
  localparam logic [31:0] USR = 32'h0000_00f0; // user status
  localparam logic [31:0] VB = 32'h8c00_0000; // vector base
  localparam logic [31:0] PC = 32'h0c00_1236; // faulting pc
  localparam logic [31:0] BPC = 32'h0c00_1234; // delayed branch pc
  logic clk_sys_i = 1'b0;
  logic resetn_i;
  logic lk_req_i, lk_store_i, lk_delay_slot_i, index_hash_mode_i;
  logic [31:0] lk_vaddr_i, lk_pc_i, lk_branch_pc_i, status_i, vector_base_i;
  logic page_entry_high_reg_we_i, page_entry_low_reg_we_i, rc_we_i, load_xlate_entry_op_i;
  logic [31:0] sw_wdata_i;
  logic ma_req_i, ma_write_i;
  logic [1:0] ma_size_i;
  logic [31:0] ma_addr_i, ma_wdata_i;
  logic lk_done_o, lk_hit_o, fault_o, ma_ack_o, ma_err_o;
  logic [11:0] exc_code_o;
  logic [31:0] fault_addr_o, page_entry_high_o, page_entry_low_o, saved_pc_o;
  logic [31:0] saved_status_o, status_o, vector_pc_o, ma_rdata_o;
  logic [1:0] replace_way_o;
  logic cmd_go; // command to the software model
  logic [1:0] cmd;
  logic [31:0] cmd_data;
  logic [7:0] space_id_tag_v; // space id written with each page-entry-high
  int mismatches = 0;
  int checks_done = 0;
  // 50 MHz clock
  always #10 clk_sys_i = ~clk_sys_i;
  tlf_fault_map dut_u (.clk_sys_i, .resetn_i, .lk_req_i, .lk_vaddr_i, .lk_store_i,
    .lk_pc_i, .lk_delay_slot_i, .lk_branch_pc_i, .status_i, .vector_base_i,
    .index_hash_mode_i, .page_entry_high_reg_we_i, .page_entry_low_reg_we_i, .rc_we_i, .sw_wdata_i,
    .load_xlate_entry_op_i, .ma_req_i, .ma_write_i, .ma_size_i, .ma_addr_i,
    .ma_wdata_i, .lk_done_o, .lk_hit_o, .fault_o, .exc_code_o, .fault_addr_o,
    .page_entry_high_o, .page_entry_low_o, .replace_way_o, .saved_pc_o,
    .saved_status_o, .status_o, .vector_pc_o, .ma_ack_o, .ma_err_o, .ma_rdata_o);
  tlf_sw_model sw_u (.clk_sys_i, .resetn_i, .cmd_go_i(cmd_go), .cmd_i(cmd),
    .cmd_data_i(cmd_data), .page_entry_high_reg_we_o(page_entry_high_reg_we_i), .page_entry_low_reg_we_o(page_entry_low_reg_we_i),
    .rc_we_o(rc_we_i), .load_op_o(load_xlate_entry_op_i), .sw_wdata_o(sw_wdata_i));
  // closing report, reached from the main sequence or the watchdog
  task give_verdict;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // page-entry-low word: valid, rights, 4k size, written, shared
  function automatic logic [31:0] pel(logic v, logic [1:0] r, logic d);
    return {23'h0, v, 1'b0, r, 1'b1, 1'b0, d, 1'b1, 1'b0};
  endfunction
  // one software command through the model
  task automatic sw(input logic [1:0] c, input logic [31:0] d);
    @(posedge clk_sys_i);
    cmd_go <= 1'b1;
    cmd <= c;
    cmd_data <= d;
    @(posedge clk_sys_i);
    cmd_go <= 1'b0;
    @(posedge clk_sys_i);
  endtask
  // install an entry: page high, page low, way, load
  task automatic inst(input logic [31:0] va, input logic [1:0] w, input logic [31:0] pl);
    sw(2'h0, {va[31:10], 2'h0, space_id_tag_v});
    sw(2'h1, pl);
    sw(2'h2, {30'h0, w});
    sw(2'h3, 32'h0);
  endtask
  // one lookup, outputs settled on return
  task automatic look(input logic [31:0] va, input logic st, ds, input logic [31:0] s);
    @(posedge clk_sys_i);
    lk_req_i <= 1'b1;
    lk_vaddr_i <= va;
    lk_store_i <= st;
    lk_delay_slot_i <= ds;
    status_i <= s;
    @(posedge clk_sys_i);
    lk_req_i <= 1'b0;
    lk_vaddr_i <= ~va;
    #1;
  endtask
  // common capture on every fault
  task automatic fchk(input logic [31:0] va, s, input logic ds);
    `CHK("fault", 1'b1, fault_o)
    `CHK("done", 1'b1, lk_done_o)
    `CHK("vector", VB + TLF_VEC_GEN_OFS, vector_pc_o)
    `CHK("tea", va, fault_addr_o)
    `CHK("page_entry_high_reg", va[31:10], page_entry_high_o[31:10])
    `CHK("spc", ds ? BPC : PC, saved_pc_o)
    `CHK("ssr", s, saved_status_o)
    `CHK("sr", s | 32'h7000_0000, status_o)
  endtask
  // one mapped access, answer settled on return
  task automatic map(input logic wr, input logic [1:0] sz, input logic [31:0] a, d, s);
    @(posedge clk_sys_i);
    ma_req_i <= 1'b1;
    ma_write_i <= wr;
    ma_size_i <= sz;
    ma_addr_i <= a;
    ma_wdata_i <= d;
    status_i <= s;
    @(posedge clk_sys_i);
    ma_req_i <= 1'b0;
    ma_wdata_i <= ~d;
    #1;
  endtask
  // hit, then invalid fault on load and on store in a delay slot
  task t_inv;
    inst(32'h0001_3000, 2'h0, pel(1'b1, 2'h3, 1'b1));
    look(32'h0001_3004, 1'b0, 1'b0, USR);
    `CHK("hit", 1'b1, lk_hit_o)
    inst(32'h0002_5000, 2'h2, pel(1'b0, 2'h3, 1'b1));
    look(32'h0002_5008, 1'b0, 1'b0, USR);
    fchk(32'h0002_5008, USR, 1'b0);
    `CHK("inv ld", TLF_EXC_INV_LD, exc_code_o)
    `CHK("inv way", 2'h2, replace_way_o)
    look(32'h0002_5ffc, 1'b1, 1'b1, PRIV);
    fchk(32'h0002_5ffc, PRIV, 1'b1);
    `CHK("inv st", TLF_EXC_INV_ST, exc_code_o)
    $display("test invalid done");
  endtask
  // protection faults in way 1 on a privileged read-only page
  task t_prot;
    inst(32'h0003_7000, 2'h1, pel(1'b1, 2'h0, 1'b1));
    look(32'h0003_7010, 1'b0, 1'b0, PRIV);
    `CHK("ro hit", 1'b1, lk_hit_o)
    look(32'h0003_7014, 1'b1, 1'b0, PRIV);
    fchk(32'h0003_7014, PRIV, 1'b0);
    `CHK("prot st", TLF_EXC_PROT_ST, exc_code_o)
    `CHK("prot way", 2'h1, replace_way_o)
    look(32'h0003_7018, 1'b0, 1'b1, USR);
    fchk(32'h0003_7018, USR, 1'b1);
    `CHK("prot ld", TLF_EXC_PROT_LD, exc_code_o)
    // 1k page in way 0: offset bits 11:10 take part in the match
    inst(32'h0006_1400, 2'h0, pel(1'b1, 2'h3, 1'b1) & ~32'h10);
    look(32'h0006_1400, 1'b0, 1'b0, USR);
    `CHK("1k hit", 1'b1, lk_hit_o)
    // other 1k slot of the same 4k region: a miss leaves the capture alone
    look(32'h0006_1800, 1'b1, 1'b0, USR);
    `CHK("miss done", 1'b1, lk_done_o)
    `CHK("miss hit", 1'b0, lk_hit_o)
    `CHK("miss fault", 1'b0, fault_o)
    `CHK("miss code", TLF_EXC_PROT_LD, exc_code_o)
    `CHK("miss tea", 32'h0003_7018, fault_addr_o)
    $display("test protection done");
  endtask
  // first write on a clean page in way 3, then the handler reload
  task t_firstw;
    inst(32'h0004_9000, 2'h3, pel(1'b1, 2'h3, 1'b0));
    look(32'h0004_9020, 1'b0, 1'b0, USR);
    `CHK("clean ld", 1'b1, lk_hit_o)
    look(32'h0004_9024, 1'b0 + 1'b1, 1'b0, USR);
    fchk(32'h0004_9024, USR, 1'b0);
    `CHK("fw code", TLF_EXC_FIRST_WR, exc_code_o)
    `CHK("fw way", 2'h3, replace_way_o)
    sw(2'h1, pel(1'b1, 2'h3, 1'b1));
    sw(2'h3, 32'h0);
    `CHK("page_entry_low_reg", pel(1'b1, 2'h3, 1'b1), page_entry_low_o)
    sw(2'h3, 32'h0);
    look(32'h0004_9024, 1'b1, 1'b0, USR);
    `CHK("fw retry", 1'b1, lk_hit_o)
    $display("test first write done");
  endtask
  // mapped address array: all ways, write and read, refusals, hashing
  task t_map;
    for (int w = 0; w < 4; w++)
    begin
      map(1'b0, TLF_SIZE_LONG, 32'hf201_3000 | (w << 8), 32'h0, PRIV);
      `CHK("aa rd", (w == 0) ? 32'h0001_3100 : 32'h0, ma_rdata_o)
    end
    map(1'b1, TLF_SIZE_LONG, 32'hf201_f100, 32'h00ab_f15a, PRIV);
    `CHK("aa wr ack", 1'b1, ma_ack_o)
    map(1'b1, 2'h1, 32'hf201_f100, 32'h0, PRIV);
    `CHK("size err", 1'b1, ma_err_o)
    map(1'b0, TLF_SIZE_LONG, 32'hf301_f100, 32'h0, PRIV);
    `CHK("range err", 1'b1, ma_err_o)
    map(1'b0, TLF_SIZE_LONG, 32'hf201_f100, 32'h0, USR);
    `CHK("user err", 1'b1, ma_err_o)
    map(1'b0, TLF_SIZE_LONG, 32'hf201_f100, 32'h0, PRIV);
    `CHK("aa back", 32'h00ab_f15a, ma_rdata_o)
    space_id_tag_v = 8'h03;
    @(posedge clk_sys_i);
    index_hash_mode_i <= 1'b1;
    inst(32'h0005_1000, 2'h0, pel(1'b1, 2'h3, 1'b1));
    look(32'h0005_1040, 1'b0, 1'b0, USR);
    `CHK("hash hit", 1'b1, lk_hit_o)
    @(posedge clk_sys_i);
    index_hash_mode_i <= 1'b0;
    map(1'b0, TLF_SIZE_LONG, 32'hf201_2000, 32'h0, PRIV);
    `CHK("hash slot", 32'h0005_1103, ma_rdata_o)
    $display("test mapped done");
  endtask
  // watchdog against a hang
  initial
  begin
    repeat (20000) @(posedge clk_sys_i);
    mismatches++;
    give_verdict();
  end
  // main sequence
  initial
  begin
    resetn_i = 1'b0;
    {lk_req_i, lk_store_i, lk_delay_slot_i, index_hash_mode_i} = 4'h0;
    {ma_req_i, ma_write_i, cmd_go} = 3'h0;
    lk_vaddr_i = 32'h0;
    lk_pc_i = PC;
    lk_branch_pc_i = BPC;
    status_i = PRIV;
    vector_base_i = VB;
    ma_size_i = TLF_SIZE_LONG;
    ma_addr_i = 32'h0;
    ma_wdata_i = 32'h0;
    cmd = 2'h0;
    cmd_data = 32'h0;
    space_id_tag_v = 8'h00;
    repeat (12) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    @(posedge clk_sys_i);
    t_inv();
    t_prot();
    t_firstw();
    t_map();
    give_verdict();
  end
endmodule
`default_nettype wire
